// >>> rtl/host_cmd_pkg.sv
package host_cmd_pkg;
  // register offsets
  localparam logic [7:0] OFF_PARAM_ONE = 8'h0e;
  localparam logic [7:0] OFF_PARAM_ZERO = 8'h0f;
  localparam logic [7:0] OFF_COMMAND = 8'h10;
  localparam logic [7:0] OFF_PREVIOUS = 8'h11;
  localparam logic [7:0] OFF_MINOR = 8'h12;
  localparam logic [7:0] OFF_PATCH = 8'h13;
  localparam logic [7:0] OFF_STATE = 8'h1c;
  localparam logic [7:0] OFF_CONDITION = 8'h1d;
  localparam logic [7:0] OFF_CONTENTS = 8'h1e;
  localparam logic [7:0] OFF_TID = 8'h1f;
  localparam logic [7:0] OFF_RESULT_LO = 8'h20;
  localparam logic [7:0] OFF_RESULT_HI = 8'h9f;
  // command codes
  localparam logic [7:0] CMD_MEASURE = 8'h02;
  localparam logic [7:0] CMD_CALIBRATE = 8'h0a;
  localparam logic [7:0] CMD_SERIAL = 8'h47;
  localparam logic [7:0] CMD_NEW_ADDR = 8'h49;
  localparam logic [7:0] CMD_HISTOGRAM = 8'h80;
  localparam logic [7:0] CMD_STOP = 8'hff;
  // state and condition codes
  localparam logic [7:0] STATE_IDLE = 8'h00;
  localparam logic [7:0] STATE_BUSY = 8'h01;
  localparam logic [7:0] STATE_ERROR = 8'h02;
  localparam logic [7:0] COND_OK = 8'h00;
  localparam logic [7:0] COND_ERR_MIN = 8'h10;
  localparam logic [7:0] COND_ENGINE_ERR = 8'h10;
  localparam logic [7:0] COND_BAD_PARAM = 8'h11;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int RESULT_DEPTH = 128;
  localparam int SERIAL_BYTES = 4;

  typedef struct packed {
    logic [3:0] zero;
    logic pin1_expected_level;
    logic pin0_expected_level;
    logic pin1_match_mask;
    logic pin0_match_mask;
  } addr_cond_t;

  typedef struct packed {
    logic [6:0] new_addr;
    logic zero;
  } addr_byte_t;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WRITE, BUS_WRITE_ACK, BUS_READ, BUS_READ_ACK
  } bus_state_t;

  typedef enum logic {CMD_IDLE, CMD_HIST_FILL} cmd_state_t;
endpackage : host_cmd_pkg

// >>> rtl/host_command_status_unit.sv
// Function
// - 0x47 puts serial number into result area
// - 0x49 executes only when masked pins match
// - new address in bits 7:1, bit0 zero
// - 0x80 starts raw histogram readout
// - histogram fill writes results; end updates contents code, tid
// - 0xff aborts everything, returns to idle
// - previous shows last command, or running 02/0a
// - state reads 2 on error only
// - condition 00-0f ok, 10-ff error
// - tid changes on each register map update
`timescale 1ns/100ps
module host_command_status_unit
  import host_cmd_pkg::*;
#(
  parameter logic [6:0] DEFAULT_BUS_ADDR = 7'h41,
  parameter logic [7:0] MINOR_REV = 8'h00, // arbitrary
  parameter logic [7:0] PATCH_REV = 8'h00, // arbitrary
  parameter int DEPTH = RESULT_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // i2c pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // general purpose pin levels
  input wire logic general_pin_zero,
  input wire logic general_pin_one,
  // identity
  input wire logic [8*SERIAL_BYTES-1:0] serial_number,
  // histogram source
  output logic hist_req,
  input wire logic hist_valid,
  input wire logic [7:0] hist_data,
  // measurement engine
  output logic engine_start,
  output logic [7:0] engine_code,
  output logic engine_stop,
  input wire logic engine_busy,
  input wire logic engine_done,
  input wire logic engine_error
);
  localparam logic [7:0] LAST_IDX = 8'(DEPTH - 1);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // synchronisers
  logic [1:0] scl_sync, sda_sync, pin0_sync, pin1_sync;
  logic scl_prev, sda_prev;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      pin0_sync <= 2'h0;
      pin1_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      pin0_sync <= {pin0_sync[0], general_pin_zero};
      pin1_sync <= {pin1_sync[0], general_pin_one};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end
  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire bus_start = scl & scl_prev & sda_prev & ~sda;
  wire bus_stop = scl & scl_prev & ~sda_prev & sda;
  // register state
  logic [7:0] param_byte_zero, param_byte_one, last_command_code, running_code;
  logic [7:0] condition, contents, tid, fill_idx, shreg, ptr;
  logic [6:0] dev_addr;
  logic [7:0] result [DEPTH];
  cmd_state_t cmd_state;
  // i2c slave
  bus_state_t bus_state;
  logic [3:0] bit_cnt;
  logic addr_hit, rw, first_byte, wr_en;
  logic [7:0] rd_byte;
  wire byte_done = (bit_cnt == BITS_PER_BYTE);
  always_comb rd_byte = read_reg(ptr);
  wire ack_drive = (bus_state == BUS_ADDR_ACK && addr_hit) || bus_state == BUS_WRITE_ACK;
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive || (bus_state == BUS_READ && !shreg[7]);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_state <= BUS_IDLE;
      shreg <= RESET_BYTE;
      ptr <= RESET_BYTE;
      bit_cnt <= 4'h0;
      addr_hit <= 1'b0;
      rw <= 1'b0;
      first_byte <= 1'b0;
      wr_en <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        bus_state <= BUS_ADDR;
        bit_cnt <= 4'h0;
      end else if (bus_stop) begin
        bus_state <= BUS_IDLE;
      end else begin
        unique case (bus_state)
          BUS_IDLE: ;
          BUS_ADDR, BUS_WRITE: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              bit_cnt <= 4'h0;
              if (bus_state == BUS_ADDR) begin
                addr_hit <= (shreg[7:1] == dev_addr);
                rw <= shreg[0];
                first_byte <= 1'b1;
                bus_state <= BUS_ADDR_ACK;
              end else begin
                bus_state <= BUS_WRITE_ACK;
                if (first_byte) begin
                  ptr <= shreg;
                  first_byte <= 1'b0;
                end else begin
                  wr_en <= 1'b1;
                end
              end
            end
          end
          BUS_ADDR_ACK: begin
            if (scl_fall) begin
              if (!addr_hit) begin
                bus_state <= BUS_IDLE;
              end else if (rw) begin
                shreg <= rd_byte;
                ptr <= ptr + 8'h01;
                bus_state <= BUS_READ;
              end else begin
                bus_state <= BUS_WRITE;
              end
            end
          end
          BUS_WRITE_ACK: begin
            if (scl_fall) begin
              bus_state <= BUS_WRITE;
            end
          end
          BUS_READ: begin
            if (scl_fall) begin
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                bus_state <= BUS_READ_ACK;
                bit_cnt <= 4'h0;
              end
            end
          end
          BUS_READ_ACK: begin
            if (scl_rise && sda) begin
              bus_state <= BUS_IDLE;
            end else if (scl_fall) begin
              shreg <= rd_byte;
              ptr <= ptr + 8'h01;
              bus_state <= BUS_READ;
            end
          end
        endcase
      end
      if (wr_en) ptr <= ptr + 8'h01;
    end
  end
  // register write decode
  wire cmd_go = wr_en && ptr == OFF_COMMAND;
  wire [7:0] cmd = shreg;
  wire addr_cond_t cond_p = addr_cond_t'(param_byte_zero);
  wire addr_byte_t addr_p = addr_byte_t'(param_byte_one);
  wire [1:0] pin_mask = {cond_p.pin1_match_mask, cond_p.pin0_match_mask};
  wire [1:0] pin_level = {pin1_sync[1], pin0_sync[1]};
  wire [1:0] pin_expect = {cond_p.pin1_expected_level, cond_p.pin0_expected_level};
  wire pins_match = ((pin_mask & pin_level) == pin_expect);
  wire addr_bad = (cond_p.zero != 4'h0) || addr_p.zero;
  wire fill_last = cmd_state == CMD_HIST_FILL && hist_valid && fill_idx == LAST_IDX;
  wire is_error = condition >= COND_ERR_MIN;
  assign hist_req = (cmd_state == CMD_HIST_FILL);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      param_byte_zero <= RESET_BYTE;
      param_byte_one <= RESET_BYTE;
    end else if (wr_en && ptr == OFF_PARAM_ZERO) begin
      param_byte_zero <= shreg;
    end else if (wr_en && ptr == OFF_PARAM_ONE) begin
      param_byte_one <= shreg;
    end
  end
  // command execution
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_state <= CMD_IDLE;
      fill_idx <= RESET_BYTE;
      last_command_code <= RESET_BYTE;
      running_code <= RESET_BYTE;
      condition <= COND_OK;
      contents <= RESET_BYTE;
      tid <= RESET_BYTE;
      dev_addr <= DEFAULT_BUS_ADDR;
      engine_start <= 1'b0;
      engine_stop <= 1'b0;
      engine_code <= RESET_BYTE;
    end else begin
      engine_start <= 1'b0;
      engine_stop <= 1'b0;
      if (cmd_go) begin
        condition <= COND_OK;
        unique case (cmd)
          CMD_STOP: begin
            cmd_state <= CMD_IDLE;
            engine_stop <= 1'b1;
            last_command_code <= cmd;
          end
          CMD_SERIAL: begin
            for (int i = 0; i < SERIAL_BYTES; i++) begin
              result[i] <= serial_number[8*i +: 8];
            end
            contents <= CMD_SERIAL;
            tid <= tid + 8'h01;
            last_command_code <= cmd;
          end
          CMD_NEW_ADDR: begin
            if (addr_bad) condition <= COND_BAD_PARAM;
            else if (pins_match) dev_addr <= addr_p.new_addr;
            last_command_code <= cmd;
          end
          CMD_HISTOGRAM: begin
            cmd_state <= CMD_HIST_FILL;
            fill_idx <= RESET_BYTE;
          end
          default: begin
            engine_start <= 1'b1;
            engine_code <= cmd;
            running_code <= cmd;
          end
        endcase
      end else if (hist_req && hist_valid) begin
        result[fill_idx[6:0]] <= hist_data;
        fill_idx <= fill_idx + 8'h01;
        if (fill_last) begin
          cmd_state <= CMD_IDLE;
          contents <= CMD_HISTOGRAM;
          tid <= tid + 8'h01;
          last_command_code <= CMD_HISTOGRAM;
        end
      end else if (engine_done) begin
        last_command_code <= running_code;
        tid <= tid + 8'h01;
      end
      if (engine_error) condition <= COND_ENGINE_ERR;
    end
  end
  // read side
  wire prev_shows_running = engine_busy &&
    (running_code == CMD_MEASURE || running_code == CMD_CALIBRATE);
  wire [7:0] previous_command_echo = prev_shows_running ? running_code : last_command_code;
  wire [7:0] operation_state = is_error ? STATE_ERROR
    : (engine_busy || hist_req) ? STATE_BUSY : STATE_IDLE;
  wire [7:0] general_condition = condition;
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] d;
    d = RESET_BYTE;
    if (a >= OFF_RESULT_LO && a <= OFF_RESULT_HI) d = result[7'(a - OFF_RESULT_LO)];
    else if (a == OFF_PARAM_ZERO) d = param_byte_zero;
    else if (a == OFF_PARAM_ONE) d = param_byte_one;
    else if (a == OFF_PREVIOUS) d = previous_command_echo;
    else if (a == OFF_MINOR) d = MINOR_REV;
    else if (a == OFF_PATCH) d = PATCH_REV;
    else if (a == OFF_STATE) d = operation_state;
    else if (a == OFF_CONDITION) d = general_condition;
    else if (a == OFF_CONTENTS) d = contents;
    else if (a == OFF_TID) d = tid;
    return d;
  endfunction : read_reg
  property p_serial;
    cmd_go && cmd == CMD_SERIAL |=> contents == CMD_SERIAL && result[0] == serial_number[7:0];
  endproperty
  a_serial: assert property (p_serial) else $error("serial readout not posted");
  property p_addr_gate;
    cmd_go && cmd == CMD_NEW_ADDR && !pins_match |=> $stable(dev_addr);
  endproperty
  a_addr_gate: assert property (p_addr_gate) else $error("address changed without match");
  property p_addr_take;
    cmd_go && cmd == CMD_NEW_ADDR && pins_match && !addr_bad
    |=> dev_addr == $past(addr_p.new_addr);
  endproperty
  a_addr_take: assert property (p_addr_take) else $error("new address not taken");
  property p_bad_param;
    cmd_go && cmd == CMD_NEW_ADDR && addr_bad && !engine_error
    |=> condition == COND_BAD_PARAM && $stable(dev_addr);
  endproperty
  a_bad_param: assert property (p_bad_param) else $error("bad address byte accepted");
  property p_hist_start;
    cmd_go && cmd == CMD_HISTOGRAM |=> hist_req && fill_idx == RESET_BYTE;
  endproperty
  a_hist_start: assert property (p_hist_start) else $error("histogram not started");
  sequence s_fill_end;
    fill_last && !cmd_go;
  endsequence
  sequence s_map_posted;
    contents == CMD_HISTOGRAM && !hist_req;
  endsequence
  property p_hist_done;
    s_fill_end |=> s_map_posted and (tid == 8'($past(tid) + 8'h01));
  endproperty
  a_hist_done: assert property (p_hist_done) else $error("histogram end not posted");
  property p_stop;
    cmd_go && cmd == CMD_STOP |=> !hist_req && engine_stop ##1 !engine_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");
  property p_prev;
    engine_busy && running_code == CMD_MEASURE |-> previous_command_echo == CMD_MEASURE;
  endproperty
  a_prev: assert property (p_prev) else $error("previous not showing running");
  property p_state;
    engine_error |=> operation_state == STATE_ERROR;
  endproperty
  a_state: assert property (p_state) else $error("error not shown in state");
  property p_engine_err;
    engine_error |=> general_condition >= COND_ERR_MIN;
  endproperty
  a_engine_err: assert property (p_engine_err) else $error("error not flagged");
  property p_tid_serial;
    cmd_go && cmd == CMD_SERIAL |=> tid != $past(tid);
  endproperty
  a_tid_serial: assert property (p_tid_serial) else $error("tid unchanged on update");
endmodule : host_command_status_unit

// >>> verification/i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
  // clock
  input wire logic clk_sys,
  // device pull-down
  input wire logic sda_oe,
  // bus lines seen by the device
  output logic scl_in,
  output logic sda_in
);
  localparam int HALF = 5;
  logic scl = 1'b1;
  logic sda_drv = 1'b1;
  // pull-up: a released line reads high
  assign scl_in = scl;
  assign sda_in = sda_drv & ~sda_oe;

  task automatic wait_half();
    repeat (HALF) @(posedge clk_sys);
  endtask : wait_half

  task automatic start_cond();
    wait_half();
    sda_drv <= 1'b1;
    wait_half();
    scl <= 1'b1;
    wait_half();
    sda_drv <= 1'b0;
    wait_half();
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_half();
    sda_drv <= 1'b0;
    wait_half();
    scl <= 1'b1;
    wait_half();
    sda_drv <= 1'b1;
    wait_half();
  endtask : stop_cond

  // data moves only mid low phase, never at the clock fall
  task automatic clock_bit(input logic b, output logic got);
    wait_half();
    sda_drv <= b;
    wait_half();
    scl <= 1'b1;
    wait_half();
    got = sda_in;
    scl <= 1'b0;
  endtask : clock_bit

  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], b);
      rx[i] = b;
    end
    clock_bit(last, b);
    ack = ~b;
  endtask : xfer
endmodule : i2c_host_model

// >>> verification/tb_host_command_status_unit.sv
`timescale 1ns/100ps
module tb_host_command_status_unit;
  import host_cmd_pkg::*;
  logic clk_sys, rst, scl_in, sda_in, sda_out, sda_oe;
  logic general_pin_zero, general_pin_one, hist_req, hist_valid;
  logic [31:0] serial_number;
  logic [7:0] hist_data, engine_code;
  logic engine_start, engine_stop, engine_busy, engine_done, engine_error;
  logic [6:0] cur_addr = 7'h41;
  logic [7:0] n_start = 8'h00;
  logic [7:0] n_stop = 8'h00;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cycles = 0;

  host_command_status_unit i_host_command_status_unit (.clk_sys(clk_sys), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .general_pin_zero(general_pin_zero), .general_pin_one(general_pin_one),
    .serial_number(serial_number), .hist_req(hist_req), .hist_valid(hist_valid),
    .hist_data(hist_data), .engine_start(engine_start), .engine_code(engine_code),
    .engine_stop(engine_stop), .engine_busy(engine_busy), .engine_done(engine_done),
    .engine_error(engine_error));
  i2c_host_model i_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl_in(scl_in),
    .sda_in(sda_in));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] p1, input logic [7:0] p0, input logic [7:0] c);
    logic [7:0] b [5] = '{{cur_addr, 1'b0}, OFF_PARAM_ONE, p1, p0, c};
    logic [7:0] d;
    logic a;
    i_host.start_cond();
    foreach (b[i]) begin
      i_host.xfer(b[i], 1'b1, d, a);
      check({7'h0, a}, 8'h01);
    end
    i_host.stop_cond();
  endtask : wr

  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    logic a;
    i_host.start_cond();
    i_host.xfer({cur_addr, 1'b0}, 1'b1, d, a);
    check({7'h0, a}, 8'h01);
    i_host.xfer(off, 1'b1, d, a);
    i_host.start_cond();
    i_host.xfer({cur_addr, 1'b1}, 1'b1, d, a);
    i_host.xfer(8'hff, 1'b1, d, a);
    i_host.stop_cond();
  endtask : rd

  task automatic probe(input logic [6:0] dev, input logic exp);
    logic [7:0] d;
    logic a;
    i_host.start_cond();
    i_host.xfer({dev, 1'b0}, 1'b1, d, a);
    i_host.stop_cond();
    check({7'h0, a}, {7'h0, exp});
  endtask : probe

  task automatic run_reset();
    logic [7:0] offs [6] = '{OFF_PREVIOUS, OFF_MINOR, OFF_PATCH, OFF_STATE, OFF_CONDITION,
      8'ha0};
    logic [7:0] d;
    foreach (offs[i]) begin
      rd(offs[i], d);
      check(d, 8'h00);
    end
    check({7'h0, sda_out}, 8'h00);
    check(engine_code, 8'h00);
    $display("test reset values done");
  endtask : run_reset

  task automatic run_serial();
    logic [7:0] d;
    wr(8'h00, 8'h00, CMD_SERIAL);
    for (int i = 0; i < SERIAL_BYTES; i++) begin
      rd(OFF_RESULT_LO + 8'(i), d);
      check(d, serial_number[8*i +: 8]);
    end
    rd(OFF_CONTENTS, d);
    check(d, CMD_SERIAL);
    rd(OFF_PREVIOUS, d);
    check(d, CMD_SERIAL);
    $display("test serial done");
  endtask : run_serial

  task automatic run_addr();
    logic [7:0] d;
    wr(8'h44, 8'h0b, CMD_NEW_ADDR);
    probe(7'h41, 1'b1);
    wr(8'h44, 8'h07, CMD_NEW_ADDR);
    probe(7'h41, 1'b0);
    probe(7'h22, 1'b1);
    cur_addr = 7'h22;
    wr(8'h82, 8'h00, CMD_NEW_ADDR);
    probe(7'h22, 1'b0);
    probe(7'h41, 1'b1);
    cur_addr = 7'h41;
    wr(8'h45, 8'h00, CMD_NEW_ADDR);
    rd(OFF_CONDITION, d);
    check(d, COND_BAD_PARAM);
    probe(7'h22, 1'b0);
    $display("test address change done");
  endtask : run_addr

  task automatic run_hist();
    logic [7:0] tid0;
    logic [7:0] d;
    rd(OFF_TID, tid0);
    wr(8'h00, 8'h00, CMD_HISTOGRAM);
    check({7'h0, hist_req}, 8'h01);
    for (int i = 0; i < RESULT_DEPTH; i++) begin
      @(posedge clk_sys);
      hist_valid <= 1'b1;
      hist_data <= 8'(i) ^ 8'h5a;
    end
    @(posedge clk_sys);
    hist_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({7'h0, hist_req}, 8'h00);
    rd(OFF_RESULT_LO, d);
    check(d, 8'h5a);
    rd(OFF_RESULT_HI, d);
    check(d, 8'h25);
    rd(OFF_CONTENTS, d);
    check(d, CMD_HISTOGRAM);
    rd(OFF_TID, d);
    check(d, tid0 + 8'h01);
    $display("test histogram done");
  endtask : run_hist

  task automatic run_hist_abort();
    logic [7:0] s0;
    logic [7:0] d;
    s0 = n_stop;
    wr(8'h00, 8'h00, CMD_HISTOGRAM);
    check({7'h0, hist_req}, 8'h01);
    wr(8'h00, 8'h00, CMD_STOP);
    check(n_stop - s0, 8'h01);
    check({7'h0, hist_req}, 8'h00);
    rd(OFF_STATE, d);
    check(d, STATE_IDLE);
    $display("test histogram abort done");
  endtask : run_hist_abort

  task automatic run_engine(input logic [7:0] code, input logic err);
    logic [7:0] tid0;
    logic [7:0] d;
    logic [7:0] s0;
    s0 = n_start;
    rd(OFF_TID, tid0);
    wr(8'h00, 8'h00, code);
    check(n_start - s0, 8'h01);
    check(engine_code, code);
    engine_busy <= 1'b1;
    rd(OFF_PREVIOUS, d);
    check(d, code);
    rd(OFF_STATE, d);
    check(d, STATE_BUSY);
    if (err) begin
      engine_error <= 1'b1;
      @(posedge clk_sys);
      engine_error <= 1'b0;
      rd(OFF_STATE, d);
      check(d, STATE_ERROR);
      rd(OFF_CONDITION, d);
      check(d, COND_ENGINE_ERR);
      s0 = n_stop;
      wr(8'h00, 8'h00, CMD_STOP);
      check(n_stop - s0, 8'h01);
      engine_busy <= 1'b0;
      rd(OFF_STATE, d);
      check(d, STATE_IDLE);
      rd(OFF_CONDITION, d);
      check(d, COND_OK);
      rd(OFF_PREVIOUS, d);
      check(d, CMD_STOP);
    end else begin
      engine_done <= 1'b1;
      engine_busy <= 1'b0;
      @(posedge clk_sys);
      engine_done <= 1'b0;
      rd(OFF_TID, d);
      check(d, tid0 + 8'h01);
      rd(OFF_PREVIOUS, d);
      check(d, code);
    end
    $display("test engine command done");
  endtask : run_engine

  // pulse monitors and run limit
  always @(posedge clk_sys) begin
    n_cycles <= n_cycles + 1;
    if (engine_start === 1'b1) n_start <= n_start + 8'h01;
    if (engine_stop === 1'b1) n_stop <= n_stop + 8'h01;
    if (n_cycles == 90000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    general_pin_zero = 1'b1;
    general_pin_one = 1'b0;
    serial_number = 32'h9e3c_51a7;
    hist_valid = 1'b0;
    hist_data = 8'h00;
    engine_busy = 1'b0;
    engine_done = 1'b0;
    engine_error = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    run_reset();
    run_serial();
    run_addr();
    run_hist();
    run_hist_abort();
    run_engine(CMD_CALIBRATE, 1'b0);
    run_engine(CMD_MEASURE, 1'b1);
    report_and_stop();
  end
endmodule : tb_host_command_status_unit
